// ==== hw/csf_pkg.sv ====
// Constants, register map and encodings shared by the processor-state block.
package csf_pkg;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned SP_LOW_W   = 5;
  localparam logic [5:0]  SP_HI      = 6'h03;
  localparam logic [10:0] SP_RESET   = 11'h07f;

  // Register byte offsets on the bus.
  localparam logic [7:0] REG_STACK   = 8'h00;
  localparam logic [7:0] REG_FLAGS   = 8'h04;
  localparam logic [7:0] REG_PC      = 8'h08;
  localparam logic [7:0] REG_ACCIDX  = 8'h0c;
  localparam logic [7:0] REG_CMD     = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_PROBE   = 8'h18;
  localparam logic [7:0] REG_PORTWIN = 8'h1c;
  localparam logic [7:0] REG_VARIANT = 8'h20;

  // Flag bit positions in the result flags register.
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_I = 3;
  localparam int unsigned FLG_H = 4;
  localparam logic [4:0]  CC_RESET = 5'h08;

  // Command word fields.
  localparam int unsigned CMD_CODE_LSB = 0;
  localparam int unsigned CMD_OPND_LSB = 8;
  localparam int unsigned CMD_TGT_LSB  = 16;

  localparam logic [3:0] CMD_NOP  = 4'h0;
  localparam logic [3:0] CMD_RSP  = 4'h1;
  localparam logic [3:0] CMD_CALL = 4'h2;
  localparam logic [3:0] CMD_RET  = 4'h3;
  localparam logic [3:0] CMD_SWI  = 4'h4;
  localparam logic [3:0] CMD_RTI  = 4'h5;
  localparam logic [3:0] CMD_ADD  = 4'h6;
  localparam logic [3:0] CMD_ADC  = 4'h7;
  localparam logic [3:0] CMD_SUB  = 4'h8;
  localparam logic [3:0] CMD_AND  = 4'h9;
  localparam logic [3:0] CMD_LSL  = 4'ha;
  localparam logic [3:0] CMD_ROR  = 4'hb;
  localparam logic [3:0] CMD_BTST = 4'hc;
  localparam logic [3:0] CMD_CLI  = 4'hd;
  localparam logic [3:0] CMD_SEI  = 4'he;

  localparam logic [2:0] CALL_BYTES = 3'd2;
  localparam logic [2:0] INT_BYTES  = 3'd5;

  // Vector addresses (high byte first).
  localparam logic [10:0] VEC_TIMER = 11'h7f8;
  localparam logic [10:0] VEC_EXT   = 11'h7fa;
  localparam logic [10:0] VEC_SWI   = 11'h7fc;
  localparam logic [10:0] VEC_RESET = 11'h7fe;

  // Address map boundaries.
  localparam logic [10:0] IO_TOP         = 11'h00f;
  localparam logic [10:0] DDR_FIRST      = 11'h004;
  localparam logic [10:0] DDR_LAST       = 11'h006;
  localparam logic [10:0] RAM_BASE_LARGE = 11'h010;
  localparam logic [10:0] RAM_BASE_SMALL = 11'h040;
  localparam logic [10:0] LOROM_BASE     = 11'h080;
  localparam logic [10:0] LOROM_TOP      = 11'h0ff;
  localparam logic [10:0] MAINROM_BASE   = 11'h3c0;
  localparam logic [10:0] SELFCHK_BASE   = 11'h784;
  localparam logic [10:0] OPTION_ADDR    = 11'h784;
  localparam logic [10:0] BOOT_BASE      = 11'h785;
  localparam logic [10:0] VEC_BASE       = 11'h7f8;
  localparam logic [7:0]  DDR_READ_VAL   = 8'hff;

  localparam logic [1:0] VAR_BASE      = 2'h0;
  localparam logic [1:0] VAR_LARGE_RAM = 2'h1;
  localparam logic [1:0] VAR_BIG_ROM   = 2'h2;
  localparam logic [1:0] VAR_EPROM     = 2'h3;

  localparam logic [2:0] RGN_NONE = 3'h0;
  localparam logic [2:0] RGN_IO   = 3'h1;
  localparam logic [2:0] RGN_RAM  = 3'h2;
  localparam logic [2:0] RGN_USER = 3'h3;
  localparam logic [2:0] RGN_SELF = 3'h4;
  localparam logic [2:0] RGN_BOOT = 3'h5;
  localparam logic [2:0] RGN_OPT  = 3'h6;
  localparam logic [2:0] RGN_VEC  = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PUSH = 4'b0010,
    ST_PULL = 4'b0100,
    ST_VEC  = 4'b1000
  } csf_state_e;
endpackage : csf_pkg

// ==== hw/csf_addr_decode.sv ====
// Address-space decoder: maps an 11-bit address to a region for each variant.
`timescale 1ns/1ns
`default_nettype none
module csf_addr_decode
  import csf_pkg::*;
(
  // Address and variant.
  input  wire logic [10:0] addr,
  input  wire logic [1:0]  variant,
  // Decode result.
  output logic      [2:0]  region,
  output logic             ddrHit
);
  logic [10:0] ramBase;

  always_comb begin
    ramBase = (variant == VAR_LARGE_RAM) ? RAM_BASE_LARGE : RAM_BASE_SMALL;
    ddrHit  = (addr >= DDR_FIRST) && (addr <= DDR_LAST);
    region  = RGN_NONE;
    if (addr >= VEC_BASE) begin
      region = RGN_VEC;
    end else if (variant == VAR_EPROM) begin
      if (addr == OPTION_ADDR) begin
        region = RGN_OPT;
      end else if (addr >= BOOT_BASE) begin
        region = RGN_BOOT;
      end else if (addr >= LOROM_BASE) begin
        region = RGN_USER;
      end else if (addr >= RAM_BASE_LARGE) begin
        region = RGN_RAM;
      end else begin
        region = RGN_IO;
      end
    end else begin
      if (addr >= SELFCHK_BASE) begin
        region = RGN_SELF;
      end else if (addr >= MAINROM_BASE) begin
        region = RGN_USER;
      end else if (addr >= LOROM_BASE && addr <= LOROM_TOP) begin
        region = RGN_USER;
      end else if (addr < LOROM_BASE && addr >= ramBase) begin
        region = RGN_RAM;
      end else if (addr <= IO_TOP) begin
        region = RGN_IO;
      end
    end
  end
endmodule : csf_addr_decode
`default_nettype wire

// ==== hw/csf_core_state.sv ====
// Processor state: stack pointer, flags, stacking sequencer, interrupt latch, map probe.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module csf_core_state
  import csf_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt sources.
  input  wire logic        extIntReq_n,
  input  wire logic        timerIntReq,
  // Memory bus for stacking and vector fetch.
  output logic      [10:0] memAddr,
  output logic      [7:0]  memWdata,
  output logic             memWe,
  output logic             memRe,
  input  wire logic [7:0]  memRdata,
  // Port direction registers.
  output logic      [7:0]  portDirA,
  output logic      [7:0]  portDirB,
  output logic      [7:0]  portDirC
);
  typedef struct packed {
    csf_state_e        state;
    logic [2:0]        idx;
    logic [2:0]        cnt;
    logic              intEntry;
    logic [10:0]       vecAddr;
    logic [10:0]       sp;
    logic [4:0]        cc;
    logic [10:0]       pc;
    logic [7:0]        acc;
    logic [7:0]        xr;
    logic [31:0][7:0]  ram;
    logic              extS1;
    logic              extS2;
    logic              extPrev;
    logic              extPend;
    logic              timerPend;
    logic [1:0]        variant;
    logic [10:0]       probeAddr;
    logic [2:0]        probeRgn;
    logic              probeDdr;
    logic [3:0][7:0]   ddr;
    logic              awReady;
    logic              wReady;
    logic              awHave;
    logic              wHave;
    logic [7:0]        awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic [10:0]       memAddr;
    logic [7:0]        memWdata;
    logic              memWe;
    logic              memRe;
  } csf_core_s;

  csf_core_s s;
  csf_core_s next_s;
  logic [2:0]  decRgn;
  logic        decDdr;
  logic [31:0] wd;
  logic [3:0]  cmdCode;
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [10:0] spUp;
  logic [7:0]  pb;
  logic        coreBusy;
  logic        coreWrite;

  // Only the low five bits move; the upper bits are forced on every step.
  function automatic logic [10:0] stepSp(input logic [10:0] sp, input logic up);
    logic [SP_LOW_W-1:0] low;
    low = up ? sp[SP_LOW_W-1:0] + 5'd1 : sp[SP_LOW_W-1:0] - 5'd1;
    return {SP_HI, low};
  endfunction : stepSp

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : mergeStrb

  function automatic logic isMapped(input logic [7:0] a);
    return a == REG_STACK || a == REG_FLAGS || a == REG_PC || a == REG_ACCIDX ||
           a == REG_CMD || a == REG_STATUS || a == REG_PROBE || a == REG_PORTWIN ||
           a == REG_VARIANT;
  endfunction : isMapped

  function automatic logic [31:0] regValue(input csf_core_s st, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      REG_STACK:   v = 32'(st.sp);
      REG_FLAGS:   v = 32'(st.cc);
      REG_PC:      v = 32'(st.pc);
      REG_ACCIDX:  v = 32'({st.xr, st.acc});
      REG_STATUS:  v = 32'({st.cc[FLG_I], st.timerPend, st.extPend, st.state});
      REG_PROBE:   v = 32'({st.probeDdr, 1'b0, st.probeRgn, 5'h00, st.probeAddr});
      REG_PORTWIN: v = st.probeDdr ? 32'(DDR_READ_VAL) : 32'h0000_0000;
      REG_VARIANT: v = 32'(st.variant);
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction : regValue

  function automatic logic [7:0] pushByte(input csf_core_s st, input logic [2:0] i);
    logic [7:0] b;
    case (i)
      3'd0:    b = st.pc[7:0];
      3'd1:    b = 8'(st.pc[10:8]);
      3'd2:    b = st.xr;
      3'd3:    b = st.acc;
      default: b = 8'(st.cc);
    endcase
    return b;
  endfunction : pushByte

  csf_addr_decode uDecode (
    .addr    (s.probeAddr),
    .variant (s.variant),
    .region  (decRgn),
    .ddrHit  (decDdr)
  );

  always_comb begin
    next_s     = s;
    next_s.memWe = 1'b0;
    next_s.memRe = 1'b0;
    wd         = mergeStrb(regValue(s, s.awAddr), s.wData, s.wStrb);
    cmdCode    = wd[CMD_CODE_LSB +: 4];
    opnd       = wd[CMD_OPND_LSB +: 8];
    res        = 8'h00;
    sum9       = 9'h000;
    nib5       = 5'h00;
    spUp       = stepSp(s.sp, 1'b1);
    pb         = pushByte(s, s.idx);
    coreBusy   = s.state != ST_IDLE;
    coreWrite  = 1'b0;

    next_s.extS1    = extIntReq_n;
    next_s.extS2    = s.extS1;
    next_s.extPrev  = s.extS2;
    next_s.probeRgn = decRgn;
    next_s.probeDdr = decDdr;

    if (s_axi_awvalid && s.awReady) begin
      next_s.awHave  = 1'b1;
      next_s.awAddr  = s_axi_awaddr;
      next_s.awReady = 1'b0;
    end
    if (s_axi_wvalid && s.wReady) begin
      next_s.wHave  = 1'b1;
      next_s.wData  = s_axi_wdata;
      next_s.wStrb  = s_axi_wstrb;
      next_s.wReady = 1'b0;
    end
    if (s.bValid && s_axi_bready) begin
      next_s.bValid  = 1'b0;
      next_s.awReady = 1'b1;
      next_s.wReady  = 1'b1;
    end

    if (s.awHave && s.wHave && !s.bValid) begin
      next_s.bValid = 1'b1;
      next_s.awHave = 1'b0;
      next_s.wHave  = 1'b0;
      next_s.bResp  = RESP_OKAY;
      coreWrite = s.awAddr == REG_STACK || s.awAddr == REG_FLAGS || s.awAddr == REG_PC ||
                  s.awAddr == REG_ACCIDX || s.awAddr == REG_CMD;
      if (!isMapped(s.awAddr) || (coreWrite && coreBusy)) begin
        next_s.bResp = RESP_SLVERR;
      end else begin
        case (s.awAddr)
          REG_STACK:   next_s.sp = {SP_HI, wd[SP_LOW_W-1:0]};
          REG_FLAGS:   next_s.cc = wd[4:0];
          REG_PC:      next_s.pc = wd[ADDR_W-1:0];
          REG_ACCIDX:  {next_s.xr, next_s.acc} = wd[15:0];
          REG_PROBE:   next_s.probeAddr = wd[ADDR_W-1:0];
          REG_PORTWIN: begin
            if (s.probeDdr) begin
              next_s.ddr[s.probeAddr[1:0]] = wd[7:0];
            end
          end
          REG_VARIANT: next_s.variant = wd[1:0];
          REG_CMD: begin
            case (cmdCode)
              CMD_RSP:  next_s.sp = SP_RESET;
              CMD_CLI:  next_s.cc[FLG_I] = 1'b0;
              CMD_SEI:  next_s.cc[FLG_I] = 1'b1;
              CMD_CALL: begin
                next_s.state    = ST_PUSH;
                next_s.idx      = 3'd0;
                next_s.cnt      = CALL_BYTES;
                next_s.intEntry = 1'b0;
                next_s.vecAddr  = wd[CMD_TGT_LSB +: ADDR_W];
              end
              CMD_SWI: begin
                next_s.state    = ST_PUSH;
                next_s.idx      = 3'd0;
                next_s.cnt      = INT_BYTES;
                next_s.intEntry = 1'b1;
                next_s.vecAddr  = VEC_SWI;
              end
              CMD_RET: begin
                next_s.state = ST_PULL;
                next_s.idx   = CALL_BYTES - 3'd1;
              end
              CMD_RTI: begin
                next_s.state = ST_PULL;
                next_s.idx   = INT_BYTES - 3'd1;
              end
              CMD_ADD, CMD_ADC: begin
                sum9 = {1'b0, s.acc} + {1'b0, opnd} +
                       9'((cmdCode == CMD_ADC) & s.cc[FLG_C]);
                nib5 = {1'b0, s.acc[3:0]} + {1'b0, opnd[3:0]} +
                       5'((cmdCode == CMD_ADC) & s.cc[FLG_C]);
                res  = sum9[7:0];
                next_s.acc       = res;
                next_s.cc[FLG_H] = nib5[4];
                next_s.cc[FLG_C] = sum9[8];
              end
              CMD_SUB: begin
                sum9 = {1'b0, s.acc} - {1'b0, opnd};
                res  = sum9[7:0];
                next_s.acc       = res;
                next_s.cc[FLG_C] = sum9[8];
              end
              CMD_AND: begin
                res        = s.acc & opnd;
                next_s.acc = res;
              end
              CMD_LSL: begin
                res              = {s.acc[6:0], 1'b0};
                next_s.acc       = res;
                next_s.cc[FLG_C] = s.acc[7];
              end
              CMD_ROR: begin
                res              = {s.cc[FLG_C], s.acc[7:1]};
                next_s.acc       = res;
                next_s.cc[FLG_C] = s.acc[0];
              end
              CMD_BTST: next_s.cc[FLG_C] = s.acc[opnd[2:0]];
              default: ;
            endcase
            if (cmdCode >= CMD_ADD && cmdCode <= CMD_ROR) begin
              next_s.cc[FLG_N] = res[7];
              next_s.cc[FLG_Z] = res == 8'h00;
            end
          end
          default: ;
        endcase
      end
    end

    case (s.state)
      ST_IDLE: begin
        // A masked request stays pending and is taken once the mask clears.
        if (!coreWrite && !s.cc[FLG_I] && (s.extPend || s.timerPend)) begin
          next_s.state    = ST_PUSH;
          next_s.idx      = 3'd0;
          next_s.cnt      = INT_BYTES;
          next_s.intEntry = 1'b1;
          next_s.vecAddr  = s.extPend ? VEC_EXT : VEC_TIMER;
          if (s.extPend) begin
            next_s.extPend = 1'b0;
          end else begin
            next_s.timerPend = 1'b0;
          end
        end
      end
      ST_PUSH: begin
        next_s.ram[s.sp[SP_LOW_W-1:0]] = pb;
        next_s.memAddr  = s.sp;
        next_s.memWdata = pb;
        next_s.memWe    = 1'b1;
        next_s.sp       = stepSp(s.sp, 1'b0);
        next_s.idx      = s.idx + 3'd1;
        if (s.idx == s.cnt - 3'd1) begin
          next_s.idx = 3'd0;
          if (s.intEntry) begin
            next_s.cc[FLG_I] = 1'b1;
            next_s.state     = ST_VEC;
          end else begin
            next_s.pc    = s.vecAddr;
            next_s.state = ST_IDLE;
          end
        end
      end
      ST_PULL: begin
        next_s.sp      = spUp;
        next_s.memAddr = spUp;
        next_s.memRe   = 1'b1;
        case (s.idx)
          3'd0:    next_s.pc[7:0]  = s.ram[spUp[SP_LOW_W-1:0]];
          3'd1:    next_s.pc[10:8] = s.ram[spUp[SP_LOW_W-1:0]][2:0];
          3'd2:    next_s.xr       = s.ram[spUp[SP_LOW_W-1:0]];
          3'd3:    next_s.acc      = s.ram[spUp[SP_LOW_W-1:0]];
          default: next_s.cc       = s.ram[spUp[SP_LOW_W-1:0]][4:0];
        endcase
        next_s.idx = s.idx - 3'd1;
        if (s.idx == 3'd0) begin
          next_s.idx   = 3'd0;
          next_s.state = ST_IDLE;
        end
      end
      ST_VEC: begin
        next_s.memRe = 1'b1;
        case (s.idx)
          3'd0: begin
            next_s.memAddr = s.vecAddr;
            next_s.idx     = 3'd1;
          end
          3'd1: begin
            next_s.pc[10:8] = memRdata[2:0];
            next_s.memAddr  = s.vecAddr + 11'h001;
            next_s.idx      = 3'd2;
          end
          default: begin
            next_s.pc[7:0] = memRdata;
            next_s.memRe   = 1'b0;
            next_s.idx     = 3'd0;
            next_s.state   = ST_IDLE;
          end
        endcase
      end
      default: next_s.state = ST_IDLE;
    endcase

    // New requests are latched after consumption so a same-cycle event is kept.
    if (s.extPrev && !s.extS2) begin
      next_s.extPend = 1'b1;
    end
    if (timerIntReq) begin
      next_s.timerPend = 1'b1;
    end

    if (s.arReady && s_axi_arvalid) begin
      next_s.rData   = regValue(s, s_axi_araddr);
      next_s.rResp   = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rValid  = 1'b1;
      next_s.arReady = 1'b0;
    end
    if (s.rValid && s_axi_rready) begin
      next_s.rValid  = 1'b0;
      next_s.arReady = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s         <= '0;
      s.state   <= ST_VEC;
      s.vecAddr <= VEC_RESET;
      s.sp      <= SP_RESET;
      s.cc      <= CC_RESET;
      s.extS1   <= 1'b1;
      s.extS2   <= 1'b1;
      s.extPrev <= 1'b1;
      s.awReady <= 1'b1;
      s.wReady  <= 1'b1;
      s.arReady <= 1'b1;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awReady;
  assign s_axi_wready  = s.wReady;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_arready = s.arReady;
  assign s_axi_rdata   = s.rData;
  assign s_axi_rresp   = s.rResp;
  assign s_axi_rvalid  = s.rValid;
  assign memAddr       = s.memAddr;
  assign memWdata      = s.memWdata;
  assign memWe         = s.memWe;
  assign memRe         = s.memRe;
  assign portDirA      = s.ddr[0];
  assign portDirB      = s.ddr[1];
  assign portDirC      = s.ddr[2];
endmodule : csf_core_state
`default_nettype wire

// ==== testbench/csf_core_state_sva.sv ====
// Port checks on the processor-state block.
`timescale 1ns/1ns
`default_nettype none
module csf_core_state_sva (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset_n,
  // Memory port.
  input wire logic [10:0] memAddr,
  input wire logic        memWe,
  input wire logic        memRe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence two_push;
    memWe [*2];
  endsequence
  a_vec_first: assert property ($rose(reset_n) |-> ##[0:3] (memRe && memAddr == 11'h7fe))
    else $error("reset vector not fetched");
  a_vec_pair: assert property (memRe && memAddr == 11'h7fe |=> memRe && memAddr == 11'h7ff)
    else $error("vector low byte not fetched");
  a_push_page: assert property (memWe |-> memAddr[10:5] == 6'h03)
    else $error("push outside stack page");
  a_push_step: assert property (two_push |-> memAddr == $past(memAddr) - 11'h1)
    else $error("push address not decremented");
  a_push_alone: assert property (memWe |-> !memRe)
    else $error("push and pull together");
  a_reset_quiet: assert property ($rose(reset_n) |-> (!memWe) [*3])
    else $error("push right after reset");
  a_entry_vector: assert property (memWe [*5] |-> ##[1:4] (memRe && memAddr[10:3] == 8'hff))
    else $error("no vector fetch after entry");
  a_pull_page: assert property (memRe && memAddr < 11'h700 |-> memAddr[10:5] == 6'h03)
    else $error("pull outside stack page");
endmodule : csf_core_state_sva
`default_nettype wire

// ==== testbench/csf_mem_model.sv ====
// Memory beside the core: vector bytes and a record of stacked bytes.
`timescale 1ns/1ns
`default_nettype none
module csf_mem_model (
  // Clock and memory port.
  input  wire logic        clk,
  input  wire logic [10:0] memAddr,
  input  wire logic [7:0]  memWdata,
  input  wire logic        memWe,
  input  wire logic        memRe,
  output logic      [7:0]  memRdata
);
  logic [7:0] mem [0:2047];
  initial begin
    mem[11'h7fa] = 8'h03;
    mem[11'h7fb] = 8'h10;
    mem[11'h7fe] = 8'h01;
    mem[11'h7ff] = 8'h23;
  end
  always @(posedge clk) begin
    if (memWe) mem[memAddr] <= memWdata;
  end
  // An unselected read shows a changing pattern, never a stale byte.
  assign memRdata = memRe ? mem[memAddr] : ~memAddr[7:0];
endmodule : csf_mem_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the processor-state block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import csf_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, awV = 1'b0, wV = 1'b0, arV = 1'b0, extN = 1'b1;
  logic [7:0] awA = 8'h0, arA = 8'h0;
  logic [31:0] wD = 32'h0, rd;
  logic [1:0] rsp;
  wire logic awR, wR, bV, arR, rV, mWe, mRe;
  wire logic [1:0] bRs, rRs;
  wire logic [31:0] rData;
  wire logic [10:0] mA;
  wire logic [7:0] mWd, mRd, pdA;
  int error_cnt = 0, checks = 0, cyc = 0;
  logic [31:0] alu [8] = '{32'h1810_0106, 32'h0b00_f006, 32'h0dff_0108, 32'h1b00_0007,
                           32'h1c80_000b, 32'h1b00_000a, 32'h1b00_ff09, 32'h1a00_070c};
  logic [23:0] rg [8] = '{24'h07_07f9, 24'h04_07f7, 24'h03_0783, 24'h36_0784,
                          24'h35_0785, 24'h12_0010, 24'h33_0080, 24'h31_000f};
  csf_core_state dut (.clk(clk), .reset_n(reset_n), .clkEn(1'b1),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRs),
    .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rData), .s_axi_rresp(rRs), .s_axi_rvalid(rV),
    .s_axi_rready(1'b1), .extIntReq_n(extN), .timerIntReq(1'b0), .memAddr(mA),
    .memWdata(mWd), .memWe(mWe), .memRe(mRe), .memRdata(mRd), .portDirA(pdA),
    .portDirB(), .portDirC());
  csf_mem_model far (.clk(clk), .memAddr(mA), .memWdata(mWd), .memWe(mWe), .memRe(mRe),
    .memRdata(mRd));
  initial forever #20 clk = ~clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    do begin
      @(posedge clk);
      if (awV && awR) awV <= 1'b0;
      if (wV && wR) wV <= 1'b0;
    end while (bV !== 1'b1);
    rsp = bRs;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    arA <= a;
    arV <= 1'b1;
    do begin
      @(posedge clk);
      if (arV && arR) arV <= 1'b0;
    end while (rV !== 1'b1);
    rd = rData;
    rsp = rRs;
  endtask : axr
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    cmp(rd, exp);
  endtask : chk
  task automatic op(input logic [31:0] c);
    axw(REG_CMD, c);
    repeat (2) @(posedge clk);
    do axr(REG_STATUS); while (rd[3:0] !== 4'h1);
  endtask : op
  task automatic final_report;
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    op(32'h0);
    chk(REG_PC, 32'h123);
    chk(REG_STACK, 32'h7f);
    chk(REG_FLAGS, 32'h08);
    op(32'h0456_0002);
    chk(REG_STACK, 32'h7d);
    cmp(32'(far.mem[11'h07f]), 32'h23);
    cmp(32'(far.mem[11'h07e]), 32'h01);
    chk(REG_PC, 32'h456);
    op(32'h3);
    chk(REG_STACK, 32'h7f);
    chk(REG_PC, 32'h123);
    axw(REG_ACCIDX, 32'h0f);
    foreach (alu[i]) begin
      op({16'h0, alu[i][15:0]});
      chk(REG_ACCIDX, {24'h0, alu[i][23:16]});
      chk(REG_FLAGS, {24'h0, alu[i][31:24]});
    end
    extN <= 1'b0;
    repeat (6) @(posedge clk);
    extN <= 1'b1;
    chk(REG_STACK, 32'h7f);
    axr(REG_STATUS);
    cmp(32'(rd[4]), 32'h1);
    op(32'hd);
    chk(REG_STACK, 32'h7a);
    chk(REG_PC, 32'h310);
    chk(REG_FLAGS, 32'h1a);
    cmp(32'(far.mem[11'h07b]), 32'h12);
    op(32'h5);
    chk(REG_STACK, 32'h7f);
    chk(REG_FLAGS, 32'h12);
    op(32'h0456_0002);
    op(32'h1);
    chk(REG_STACK, 32'h7f);
    axw(REG_PROBE, 32'h004);
    axw(REG_PORTWIN, 32'h5a);
    repeat (2) @(posedge clk);
    chk(REG_PORTWIN, 32'hff);
    cmp(32'(pdA), 32'h5a);
    foreach (rg[i]) begin
      axw(REG_VARIANT, 32'(rg[i][23:20]));
      axw(REG_PROBE, 32'(rg[i][15:0]));
      repeat (2) @(posedge clk);
      axr(REG_PROBE);
      cmp(32'(rd[18:16]), 32'(rg[i][19:16]));
    end
    axr(8'h24);
    cmp(32'(rsp), 32'h2);
    final_report();
  end
endmodule : tb
bind csf_core_state csf_core_state_sva sva_i (.clk(clk), .reset_n(reset_n),
  .memAddr(memAddr), .memWe(memWe), .memRe(memRe));
`default_nettype wire
